// file: rssx_map.svh
// offsets, field positions, opcodes, constants and reset values of the exec unit
`ifndef RSSX_MAP_SVH
`define RSSX_MAP_SVH

// register port offsets
`define RSSX_REG_W 3'h0
`define RSSX_REG_STATUS 3'h1
`define RSSX_REG_BANK 3'h2
`define RSSX_REG_POWER 3'h3
`define RSSX_REG_PTR_LO 3'h4
`define RSSX_REG_PTR_HI 3'h5
`define RSSX_REG_DATA 3'h6
// status field positions
`define RSSX_ST_C 0
`define RSSX_ST_DC 1
`define RSSX_ST_Z 2
`define RSSX_ST_OV 3
`define RSSX_ST_N 4
// power field positions
`define RSSX_PW_TO 0
`define RSSX_PW_PD 1
// opcode prefixes and the full sleep word
`define RSSX_OP_RL_C 6'h0D
`define RSSX_OP_RR_C 6'h0C
`define RSSX_OP_RL_P 6'h11
`define RSSX_OP_RR_P 6'h10
`define RSSX_OP_RSUB 6'h15
`define RSSX_OP_FILL 7'h34
`define RSSX_OP_SLEEP 16'h0003
// constants and reset values
`define RSSX_FILL_VALUE 8'hFF
`define RSSX_ACCESS_SPLIT 8'h80
`define RSSX_ACCESS_HI_BANK 4'hF
`define RSSX_ACCESS_LO_BANK 4'h0
`define RSSX_RST_BYTE 8'h00
`define RSSX_RST_FLAGS 5'h00

`endif

// file: rssx_pkg.sv
// types shared by the exec unit and its users
package rssx_pkg;

  // decoded operation of the group
  typedef enum logic [2:0] {
    OP_NONE,
    OP_RL_VIA_C,
    OP_RL_PLAIN,
    OP_RR_VIA_C,
    OP_RR_PLAIN,
    OP_RSUB,
    OP_FILL,
    OP_SLEEP
  } rssx_op_t;

  // instruction phases
  typedef enum logic [2:0] {
    PH_DECODE,
    PH_READ,
    PH_PROC,
    PH_WRITE,
    PH_SLEEP
  } rssx_phase_t;

  // program word: high byte holds opcode, d and a bits
  typedef struct packed {
    logic [7:0] opHi;
    logic [7:0] fileAddr;
  } rssx_instr_t;

  // arithmetic flags
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } rssx_flags_t;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rssx_regreq_t;

endpackage

// file: rssx_exec.sv
// rotate, fill, reverse subtract and sleep execution unit with data memory
//
// Notes on behaviour
// RQ1: rotate left via carry: bit7 to carry, carry to bit0; C,N,Z set.
// RQ2: plain rotate left: bit7 wraps to bit0; carry kept; N,Z set.
// RQ3: rotate right via carry: bit0 to carry, carry to bit7; C,N,Z set.
// RQ4: plain rotate right: bit0 wraps to bit7; only N,Z set.
// RQ5: destination bit 0 writes W, 1 writes the file register back.
// RQ6: bank bit 0 uses access bank; 1 combines address with bank select.
// RQ7: fill op loads FFh into the file register; no flags change.
// RQ8: sleep clears watchdog, sets time-out, clears power-down, then halts.
// RQ9: watchdog wake from sleep clears the time-out status bit.
// RQ10: reverse subtract: W minus file minus inverted carry; N,OV,C,DC,Z set.
// RQ11: one word, one cycle: decode, read, process, write phases.
// RQ12: on subtract, carry means no borrow; cleared when a borrow occurs.
// RQ13: flags not affected by an instruction keep their values.
`timescale 1ns/10ps
`default_nettype none
`include "rssx_map.svh"

module rssx_exec
  import rssx_pkg::*;
#(
  parameter int unsigned BANKS = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // instruction feed
  input wire logic instrValid,
  input wire rssx_instr_t instrWord,
  output logic instrReady,
  output logic instrDone,
  output logic instrUnknown,
  // register port
  input wire rssx_regreq_t regReq,
  output logic [7:0] regRdata,
  // watchdog and wake
  input wire logic wakeWatchdog,
  input wire logic wakeOther,
  output logic watchdogClear,
  output logic oscStop,
  // flag view
  output rssx_flags_t flagsOut
);
  localparam int unsigned MEM_WORDS = BANKS * 256;
  localparam int unsigned AW = $clog2(MEM_WORDS);

  // ****************************************
  // state
  // ****************************************
  rssx_phase_t phase;
  rssx_op_t opReg;
  logic destFile;
  logic [AW-1:0] effAddr;
  logic [7:0] operand;
  logic [7:0] result;
  rssx_flags_t resFlags;
  logic [7:0] wReg;
  rssx_flags_t flags;
  logic [3:0] bankSel;
  logic toFlag;
  logic pdFlag;
  logic [AW-1:0] swPtr;
  logic [7:0] mem [MEM_WORDS];
  logic accept;
  logic regWrite;
  logic coreWriteW;
  logic coreWriteF;

  // ****************************************
  // functions
  // ****************************************
  // operation from the program word
  function automatic rssx_op_t decodeOp(input rssx_instr_t iw);
    rssx_op_t op;
    op = OP_NONE;
    if ({iw.opHi, iw.fileAddr} == `RSSX_OP_SLEEP) begin
      op = OP_SLEEP;
    end else if (iw.opHi[7:1] == `RSSX_OP_FILL) begin
      op = OP_FILL;
    end else begin
      unique case (iw.opHi[7:2])
        `RSSX_OP_RL_C: op = OP_RL_VIA_C;
        `RSSX_OP_RL_P: op = OP_RL_PLAIN;
        `RSSX_OP_RR_C: op = OP_RR_VIA_C;
        `RSSX_OP_RR_P: op = OP_RR_PLAIN;
        `RSSX_OP_RSUB: op = OP_RSUB;
        default: op = OP_NONE;
      endcase
    end
    return op;
  endfunction

  // data memory address from bank bit, bank select and file address
  function automatic logic [AW-1:0] bankAddr(
    input logic useBank,
    input logic [3:0] bsel,
    input logic [7:0] f
  );
    logic [3:0] bank;
    bank = bsel;
    if (!useBank) begin
      // low half is bank 0, high half the special registers
      bank = (f < `RSSX_ACCESS_SPLIT) ? `RSSX_ACCESS_LO_BANK
                                      : `RSSX_ACCESS_HI_BANK;
    end
    return AW'({bank, f});
  endfunction

  // does the op write a destination chosen by the d bit
  function automatic logic hasDest(input rssx_op_t op);
    return (op == OP_RL_VIA_C) || (op == OP_RL_PLAIN) ||
           (op == OP_RR_VIA_C) || (op == OP_RR_PLAIN) || (op == OP_RSUB);
  endfunction

  // ****************************************
  // phase sequencing
  // ****************************************
  assign accept = instrValid && instrReady;

  // RQ11 four phase cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      phase <= PH_DECODE;
    end else begin
      unique case (phase)
        PH_DECODE: phase <= accept ? PH_READ : PH_DECODE;
        PH_READ: phase <= PH_PROC;
        PH_PROC: phase <= PH_WRITE;
        PH_WRITE: phase <= (opReg == OP_SLEEP) ? PH_SLEEP : PH_DECODE;
        PH_SLEEP: phase <= (wakeWatchdog || wakeOther) ? PH_DECODE : PH_SLEEP;
      endcase
    end
  end

  // ready only while waiting in decode; drops at once on accept
  always_ff @(posedge clk_sys) begin
    if (!nrst || accept) begin
      instrReady <= 1'b0;
    end else if (phase == PH_DECODE ||
                 (phase == PH_WRITE && opReg != OP_SLEEP) ||
                 (phase == PH_SLEEP && (wakeWatchdog || wakeOther))) begin
      instrReady <= 1'b1;
    end
  end

  // decode phase latches op, d bit and effective address
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      opReg <= OP_NONE;
      destFile <= 1'b1;
      effAddr <= '0;
    end else if (accept) begin
      opReg <= decodeOp(instrWord);
      destFile <= instrWord.opHi[1];
      // RQ6 bank selection
      effAddr <= bankAddr(instrWord.opHi[0], bankSel, instrWord.fileAddr);
    end
  end

  // read phase fetches the file register
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      operand <= `RSSX_RST_BYTE;
    end else if (phase == PH_READ) begin
      operand <= mem[effAddr];
    end
  end

  // ****************************************
  // process phase
  // ****************************************
  logic [8:0] subFull;
  logic [4:0] subLow;
  logic [7:0] next_result;
  rssx_flags_t next_flags;

  // W + ~f + C is W - f - ~C in two's complement
  assign subFull = {1'b0, wReg} + {1'b0, ~operand} + {8'h00, flags.c};
  assign subLow = {1'b0, wReg[3:0]} + {1'b0, ~operand[3:0]} +
                  {4'h0, flags.c};

  // result and flags of each op
  always_comb begin
    next_result = operand;
    // RQ13 untouched flags held
    next_flags = flags;
    unique case (opReg)
      OP_RL_VIA_C: begin
        // RQ1 rotate left through carry
        next_result = {operand[6:0], flags.c};
        next_flags.c = operand[7];
      end
      OP_RL_PLAIN: begin
        // RQ2 rotate left wrap
        next_result = {operand[6:0], operand[7]};
      end
      OP_RR_VIA_C: begin
        // RQ3 rotate right through carry
        next_result = {flags.c, operand[7:1]};
        next_flags.c = operand[0];
      end
      OP_RR_PLAIN: begin
        // RQ4 rotate right wrap
        next_result = {operand[0], operand[7:1]};
      end
      OP_RSUB: begin
        // RQ10 reverse subtract with borrow
        next_result = subFull[7:0];
        // RQ12 carry is not-borrow
        next_flags.c = subFull[8];
        next_flags.dc = subLow[4];
        next_flags.ov = (wReg[7] != operand[7]) &&
                        (subFull[7] != wReg[7]);
      end
      OP_FILL: begin
        // RQ7 fill with ones
        next_result = `RSSX_FILL_VALUE;
      end
      OP_SLEEP, OP_NONE: next_result = operand;
    endcase
    if (hasDest(opReg)) begin
      next_flags.n = next_result[7];
      next_flags.z = (next_result == 8'h00);
    end
  end

  // process phase registers the outcome
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      result <= `RSSX_RST_BYTE;
      resFlags <= `RSSX_RST_FLAGS;
    end else if (phase == PH_PROC) begin
      result <= next_result;
      resFlags <= next_flags;
    end
  end

  // ****************************************
  // write phase
  // ****************************************
  // RQ5 destination choice
  assign coreWriteW = (phase == PH_WRITE) && hasDest(opReg) && !destFile;
  assign coreWriteF = (phase == PH_WRITE) &&
                      ((hasDest(opReg) && destFile) || opReg == OP_FILL);
  assign regWrite = regReq.wr;

  // working register; the core write wins over software
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wReg <= `RSSX_RST_BYTE;
    end else if (coreWriteW) begin
      wReg <= result;
    end else if (regWrite && regReq.addr == `RSSX_REG_W) begin
      wReg <= regReq.wdata;
    end
  end

  // status flags; core update wins over software
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      flags <= `RSSX_RST_FLAGS;
    end else if (phase == PH_WRITE) begin
      flags <= resFlags;
    end else if (regWrite && regReq.addr == `RSSX_REG_STATUS) begin
      flags <= regReq.wdata[4:0];
    end
  end

  // data memory; software access goes through the pointer
  always_ff @(posedge clk_sys) begin
    if (coreWriteF) begin
      mem[effAddr] <= result;
    end else if (regWrite && regReq.addr == `RSSX_REG_DATA) begin
      mem[swPtr] <= regReq.wdata;
    end
  end

  // bank select and memory pointer, software only
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      bankSel <= 4'h0;
      swPtr <= '0;
    end else if (regWrite) begin
      unique case (regReq.addr)
        `RSSX_REG_BANK: bankSel <= regReq.wdata[3:0];
        `RSSX_REG_PTR_LO: swPtr[7:0] <= regReq.wdata;
        `RSSX_REG_PTR_HI: swPtr[AW-1:8] <= regReq.wdata[AW-9:0];
        default: swPtr <= swPtr;
      endcase
    end
  end

  // ****************************************
  // sleep and power flags
  // ****************************************
  // time-out and power-down flags, active low as status bits
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      toFlag <= 1'b1;
      pdFlag <= 1'b1;
    end else if (phase == PH_WRITE && opReg == OP_SLEEP) begin
      // RQ8 sleep sets time-out, clears power-down
      toFlag <= 1'b1;
      pdFlag <= 1'b0;
    end else if (phase == PH_SLEEP && wakeWatchdog) begin
      // RQ9 watchdog wake clears time-out
      toFlag <= 1'b0;
    end
  end

  // watchdog clear pulse and oscillator stop level
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      watchdogClear <= 1'b0;
      oscStop <= 1'b0;
    end else begin
      // RQ8 clear watchdog and halt
      watchdogClear <= (phase == PH_WRITE) && (opReg == OP_SLEEP);
      if (phase == PH_WRITE && opReg == OP_SLEEP) begin
        oscStop <= 1'b1;
      end else if (phase == PH_SLEEP && (wakeWatchdog || wakeOther)) begin
        oscStop <= 1'b0;
      end
    end
  end

  // ****************************************
  // completion and read back
  // ****************************************
  // done pulses in the cycle after the write phase; unknown words run as no-ops
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      instrDone <= 1'b0;
      instrUnknown <= 1'b0;
      flagsOut <= `RSSX_RST_FLAGS;
    end else begin
      instrDone <= (phase == PH_WRITE);
      instrUnknown <= (phase == PH_WRITE) && (opReg == OP_NONE);
      flagsOut <= flags;
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!nrst || !regReq.rd) begin
      regRdata <= `RSSX_RST_BYTE;
    end else begin
      unique case (regReq.addr)
        `RSSX_REG_W: regRdata <= wReg;
        `RSSX_REG_STATUS: regRdata <= {3'h0, flags};
        `RSSX_REG_BANK: regRdata <= {4'h0, bankSel};
        `RSSX_REG_POWER: regRdata <= {6'h00, pdFlag, toFlag};
        `RSSX_REG_PTR_LO: regRdata <= swPtr[7:0];
        `RSSX_REG_PTR_HI: regRdata <= 8'(swPtr[AW-1:8]);
        `RSSX_REG_DATA: regRdata <= mem[swPtr];
        default: regRdata <= `RSSX_RST_BYTE;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: rssx_exec_properties.sv
// port assertions for the rotate, fill, subtract and sleep exec unit
`timescale 1ns/10ps
`default_nettype none
`include "rssx_map.svh"

module rssx_exec_properties
  import rssx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // instruction feed
  input wire logic instrValid,
  input wire rssx_instr_t instrWord,
  input wire logic instrReady,
  input wire logic instrDone,
  input wire logic instrUnknown,
  // register port
  input wire rssx_regreq_t regReq,
  input wire logic [7:0] regRdata,
  // sleep and flags
  input wire logic wakeWatchdog,
  input wire logic wakeOther,
  input wire logic watchdogClear,
  input wire logic oscStop,
  input wire rssx_flags_t flagsOut
);
  // ********************
  // instruction timing
  // ********************
  logic take;
  logic plainRot;

  // an accepted word; plain rotates leave carry alone
  assign take = instrValid && instrReady;
  assign plainRot = instrWord.opHi[7:3] == 5'h08;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // phase sequencing and completion
  a_done_four: assert property (
    take && instrWord != `RSSX_OP_SLEEP |-> ##4 instrDone)
    else $error("done not four cycles after accept");
  a_busy_three: assert property (
    take |=> (!instrReady)[*3])
    else $error("ready during busy phases");
  a_unknown_done: assert property (
    instrUnknown |-> instrDone)
    else $error("unknown flag without done");
  // sleep entry and wake, idle read data
  a_sleep_entry: assert property (
    take && instrWord == `RSSX_OP_SLEEP |-> ##4 watchdogClear && oscStop)
    else $error("sleep did not clear watchdog and stop");
  a_sleep_stays: assert property (
    oscStop && !wakeWatchdog && !wakeOther |=> oscStop && !instrReady)
    else $error("left sleep without a wake");
  a_wake_resume: assert property (
    oscStop && (wakeWatchdog || wakeOther) |=> !oscStop && instrReady)
    else $error("wake did not resume");
  a_rdata_idle: assert property (
    !regReq.rd |=> regRdata == 8'h00)
    else $error("read data without read");
  // untouched flags, only when software makes no register write
  a_fill_keeps: assert property (
    take && instrWord.opHi[7:1] == 7'h34 && !regReq.wr && !instrDone &&
    !$past(regReq.wr) ##1 (!regReq.wr)[*4] |=>
    flagsOut == $past(flagsOut, 5))
    else $error("fill changed flags");
  a_plain_carry: assert property (
    take && plainRot && !regReq.wr && !instrDone &&
    !$past(regReq.wr) ##1 (!regReq.wr)[*4] |=>
    flagsOut.c == $past(flagsOut.c, 5))
    else $error("plain rotate changed carry");
endmodule

bind rssx_exec rssx_exec_properties i_props (
  .clk_sys, .nrst, .instrValid, .instrWord, .instrReady, .instrDone,
  .instrUnknown, .regReq, .regRdata, .wakeWatchdog, .wakeOther,
  .watchdogClear, .oscStop, .flagsOut
);
`default_nettype wire

// file: rssx_exec_tb_top.sv
// self-checking testbench of the exec unit
`timescale 1ns/10ps
`default_nettype none
`include "rssx_map.svh"
`define CHK(nm, exp, got) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
  end \
end

module rssx_exec_tb_top
  import rssx_pkg::*;
;
  // ********************
  // stimulus and checks
  // ********************
  logic clk_sys, nrst, instrValid, instrReady, instrDone, instrUnknown;
  logic wakeWatchdog, wakeOther, watchdogClear, oscStop;
  rssx_instr_t instrWord, iw;
  rssx_regreq_t regReq;
  rssx_flags_t flagsOut;
  logic [7:0] regRdata, q, fa, fv, wv;
  logic [5:0] ops [5];
  logic [4:0] st;
  logic [3:0] bk;
  logic [11:0] ptr;
  logic [12:0] ex;
  logic dd, aa;
  int k;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  rssx_exec i_dut (.clk_sys, .nrst, .instrValid, .instrWord, .instrReady,
    .instrDone, .instrUnknown, .regReq, .regRdata, .wakeWatchdog,
    .wakeOther, .watchdogClear, .oscStop, .flagsOut);

  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one port cycle; read data only lives in the next cycle
  task automatic port(input logic [2:0] a, input logic [7:0] d,
                      input logic w, output logic [7:0] r);
    @(posedge clk_sys);
    regReq <= {a, d, w, ~w};
    @(posedge clk_sys);
    regReq <= '0;
    #1 r = regRdata;
  endtask

  task automatic put(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] r;
    port(a, d, 1'b1, r);
  endtask

  task automatic get(input logic [2:0] a, output logic [7:0] r);
    port(a, 8'h00, 1'b0, r);
  endtask

  // offer a word once ready, stop at the done cycle
  task automatic run(input rssx_instr_t w);
    int n;
    n = 0;
    while (instrReady !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1 n++;
    end
    @(posedge clk_sys);
    instrValid <= 1'b1;
    instrWord <= w;
    @(posedge clk_sys);
    instrValid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // expected {status, result}; subtract as w - f - borrow, carry = no borrow
  function automatic logic [12:0] model(input int op, input logic [7:0] f,
      input logic [7:0] w, input logic [4:0] s);
    logic [8:0] sum;
    logic [4:0] h;
    logic [7:0] r;
    logic [4:0] o;
    o = s;
    sum = {1'b0, w} - {1'b0, f} - {8'h00, ~s[0]};
    h = {1'b0, w[3:0]} - {1'b0, f[3:0]} - {4'h0, ~s[0]};
    case (op)
      0: {o[0], r} = {f, s[0]};
      1: {r, o[0]} = {s[0], f};
      2: r = {f[6:0], f[7]};
      3: r = {f[0], f[7:1]};
      4: begin
        r = sum[7:0];
        o[0] = ~sum[8];
        o[1] = ~h[4];
        o[3] = (w[7] != f[7]) && (r[7] != w[7]);
      end
      default: r = `RSSX_FILL_VALUE;
    endcase
    if (op < 5) begin
      o[4] = r[7];
      o[2] = r == 8'h00;
    end
    return {o, r};
  endfunction

  // main sequence
  initial begin
    nrst = 1'b0;
    instrValid = 1'b0;
    instrWord = '0;
    regReq = '0;
    wakeWatchdog = 1'b0;
    wakeOther = 1'b0;
    ops = '{`RSSX_OP_RL_C, `RSSX_OP_RR_C, `RSSX_OP_RL_P, `RSSX_OP_RR_P,
            `RSSX_OP_RSUB};
    k = $urandom(32'h8a84);
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    // power status is read-only; unmapped place reads zero
    put(`RSSX_REG_POWER, 8'h00);
    put(3'h7, 8'h5A);
    get(`RSSX_REG_POWER, q);
    `CHK("power", 8'h03, q)
    get(3'h7, q);
    `CHK("unmapped", 8'h00, q)
    run(16'h3800);
    `CHK("unknown", 1'b1, instrUnknown)
    // sleep, woken by another event then by the watchdog
    for (int j = 0; j < 2; j++) begin
      run(`RSSX_OP_SLEEP);
      `CHK("wd clear", 1'b1, watchdogClear)
      `CHK("osc stop", 1'b1, oscStop)
      get(`RSSX_REG_POWER, q);
      `CHK("power asleep", 8'h01, q)
      `CHK("ready asleep", 1'b0, instrReady)
      @(posedge clk_sys);
      wakeOther <= (j == 0);
      wakeWatchdog <= (j == 1);
      @(posedge clk_sys);
      wakeOther <= 1'b0;
      wakeWatchdog <= 1'b0;
      #1 `CHK("awake", 1'b0, oscStop)
      get(`RSSX_REG_POWER, q);
      `CHK("power awake", (j == 0) ? 8'h01 : 8'h00, q)
    end
    // random operands; first words straddle the access bank split
    for (int i = 0; i < 240; i++) begin
      k = $urandom_range(5);
      dd = (k == 5) ? 1'b1 : 1'($urandom);
      aa = 1'($urandom);
      fa = 8'($urandom);
      if (i < 4) fa = {i[0], {7{~i[0]}}};
      wv = 8'($urandom);
      fv = (i % 8 == 2) ? wv : 8'($urandom);
      st = 5'($urandom);
      bk = 4'($urandom);
      ptr = aa ? {bk, fa} : {fa[7] ? 4'hF : 4'h0, fa};
      iw = (k == 5) ? {`RSSX_OP_FILL, aa, fa} : {ops[k], dd, aa, fa};
      put(`RSSX_REG_W, wv);
      put(`RSSX_REG_STATUS, {3'h0, st});
      put(`RSSX_REG_BANK, {4'h0, bk});
      put(`RSSX_REG_PTR_LO, ptr[7:0]);
      put(`RSSX_REG_PTR_HI, {4'h0, ptr[11:8]});
      put(`RSSX_REG_DATA, fv);
      run(iw);
      `CHK("done", 1'b1, instrDone)
      `CHK("known", 1'b0, instrUnknown)
      ex = model(k, fv, wv, st);
      get(`RSSX_REG_W, q);
      `CHK("w", dd ? wv : ex[7:0], q)
      get(`RSSX_REG_STATUS, q);
      `CHK("status", {3'h0, ex[12:8]}, q)
      `CHK("flags out", ex[12:8], flagsOut)
      get(`RSSX_REG_DATA, q);
      `CHK("file", dd ? ex[7:0] : fv, q)
    end
    final_report();
  end
endmodule
`default_nettype wire
